/* File: logic/cri_top.sv */
// Purpose: i2c target for reading three channel registers
// Assumes: scl and sda sampled by 10 MHz aclk, open-drain sda
// Notes:   registers are loaded over axi4-lite
//
// Operation
// - read is an address transaction followed by a separate data transaction
// - target acknowledges address and the one subaddress byte
// - target acknowledges read address then sends one selected byte msb first
// - address is 01011 plus two strap bits plus direction
// - codes 01, 02, 03 select channel one, two, three
// - fields clamp 7:6, mux 5, corner 4:3, bias 2:0
// - single byte only, no auto-increment
// - registers undefined until written (reset loads 00 here); one scl cycle frees stuck acknowledge
//
// Decided for this implementation: the register offsets and the AXI4-Lite register port.
`timescale 1ns/100ps
module cri_top (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        scl_i,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe,
  input  wire logic        addr_strap_high,
  input  wire logic        addr_strap_low,
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic [1:0]       sync_tip_clamp_ch1,
  output logic             mux_sel_ch1,
  output logic [1:0]       lpf_sel_ch1,
  output logic [2:0]       bias_mode_ch1
);
  logic [1:0]          pins_s;
  logic [1:0]          strap_s;
  logic                scl_q;
  logic                sda_q;
  logic                scl_rise;
  logic                scl_fall;
  logic                start_det;
  logic                stop_det;
  logic [23:0]         ch_regs;
  logic [7:0]          status;
  cri_pkg::cri_state_t state_q;
  logic [7:0]          shift_q;
  logic [2:0]          bit_q;
  logic                read_q;
  logic [1:0]          sel_q;
  logic [6:0]          own_addr_q;
  logic [7:0]          tx_byte;
  logic                rx_nack_q;
  logic                armed_q;
  logic [cri_pkg::NUM_CH-1:0] ch_hit;
  logic [7:0]          ch_pick [cri_pkg::NUM_CH];

  cri_sync #(.WIDTH(2)) u_pin_sync (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .async_in ({scl_i, sda_i}),
    .sync_out (pins_s)
  );

  cri_sync #(.WIDTH(2)) u_strap_sync (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .async_in ({addr_strap_high, addr_strap_low}),
    .sync_out (strap_s)
  );

  cri_axil u_regs (
    .aclk          (aclk),
    .aresetn       (aresetn),
    .s_axi_awaddr  (s_axi_awaddr),
    .s_axi_awvalid (s_axi_awvalid),
    .s_axi_awready (s_axi_awready),
    .s_axi_wdata   (s_axi_wdata),
    .s_axi_wstrb   (s_axi_wstrb),
    .s_axi_wvalid  (s_axi_wvalid),
    .s_axi_wready  (s_axi_wready),
    .s_axi_bresp   (s_axi_bresp),
    .s_axi_bvalid  (s_axi_bvalid),
    .s_axi_bready  (s_axi_bready),
    .s_axi_araddr  (s_axi_araddr),
    .s_axi_arvalid (s_axi_arvalid),
    .s_axi_arready (s_axi_arready),
    .s_axi_rdata   (s_axi_rdata),
    .s_axi_rresp   (s_axi_rresp),
    .s_axi_rvalid  (s_axi_rvalid),
    .s_axi_rready  (s_axi_rready),
    .ch_regs       (ch_regs),
    .status_in     (status)
  );

  // edge and condition detect on synchronised pins
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end
    else
    begin
      scl_q <= pins_s[1];
      sda_q <= pins_s[0];
    end
  end

  assign scl_rise  = pins_s[1] && !scl_q;
  assign scl_fall  = !pins_s[1] && scl_q;
  assign start_det = pins_s[1] && scl_q && sda_q && !pins_s[0];
  assign stop_det  = pins_s[1] && scl_q && !sda_q && pins_s[0];

  // armed by first scl rise of a frame; the start's own scl fall ends no byte
  always_ff @(posedge aclk)
  begin
    if (!aresetn || start_det)
      armed_q <= 1'b0;
    else if (scl_rise)
      armed_q <= 1'b1;
  end

  // open-drain pin, only the enable moves
  always_ff @(posedge aclk)
  begin
    sda_o <= 1'b0;
  end

  // strap bits reloaded every cycle after reset release
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      own_addr_q <= 7'h00;
    else
      own_addr_q <= {cri_pkg::ADDR_FIXED, strap_s};
  end

  // selected byte, subaddress low two bits 01..11; low bits 00 read zero
  for (genvar g = 0; g < cri_pkg::NUM_CH; g++)
  begin : g_chan
    assign ch_hit[g]  = sel_q == 2'(g + 1);
    assign ch_pick[g] = ch_hit[g] ? ch_regs[8*g +: 8] : 8'h00;
  end

  always_comb
  begin
    tx_byte = 8'h00;
    for (int c = 0; c < cri_pkg::NUM_CH; c++)
      tx_byte = tx_byte | ch_pick[c];
  end

  assign status = {3'h0, read_q, rx_nack_q, state_q == cri_pkg::CRI_IDLE, sel_q};

  // bus state machine
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_q   <= cri_pkg::CRI_IDLE;
      shift_q   <= 8'h00;
      bit_q     <= 3'h0;
      read_q    <= 1'b0;
      sel_q     <= cri_pkg::SEL_RESET;
      rx_nack_q <= 1'b0;
      sda_oe    <= 1'b0;
    end
    else if (start_det)
    begin
      state_q <= cri_pkg::CRI_ADDR;
      shift_q <= 8'h00;
      bit_q   <= 3'h0;
      sda_oe  <= 1'b0;
    end
    else if (stop_det)
    begin
      state_q <= cri_pkg::CRI_IDLE;
      bit_q   <= 3'h0;
      sda_oe  <= 1'b0;
    end
    else
    begin
      case (state_q)
        cri_pkg::CRI_IDLE:
          sda_oe <= 1'b0;
        cri_pkg::CRI_ADDR, cri_pkg::CRI_RXB:
        begin
          if (scl_rise)
          begin
            shift_q <= {shift_q[6:0], pins_s[0]};
            bit_q   <= bit_q + 3'h1;
          end
          if (scl_fall && bit_q == 3'h0 && state_q == cri_pkg::CRI_ADDR
              && armed_q)
          begin
            if (shift_q[7:1] == own_addr_q)
            begin
              read_q  <= shift_q[0];
              sda_oe  <= 1'b1;
              state_q <= cri_pkg::CRI_AACK;
            end
            else
              state_q <= cri_pkg::CRI_IDLE;
          end
          else if (scl_fall && bit_q == 3'h0 && state_q == cri_pkg::CRI_RXB)
          begin
            sel_q   <= shift_q[1:0];
            sda_oe  <= 1'b1;
            state_q <= cri_pkg::CRI_RACK;
          end
        end
        cri_pkg::CRI_AACK:
          if (scl_fall)
          begin
            shift_q <= 8'h00;
            if (read_q)
            begin
              sda_oe  <= !tx_byte[7];
              shift_q <= {tx_byte[6:0], 1'b0};
              bit_q   <= 3'h1;
              state_q <= cri_pkg::CRI_TXB;
            end
            else
            begin
              sda_oe  <= 1'b0;
              bit_q   <= 3'h0;
              state_q <= cri_pkg::CRI_RXB;
            end
          end
        cri_pkg::CRI_RACK:
          if (scl_fall)
          begin
            sda_oe  <= 1'b0;
            state_q <= cri_pkg::CRI_IDLE;
          end
        cri_pkg::CRI_TXB:
          if (scl_fall)
          begin
            if (bit_q == 3'h0)
            begin
              sda_oe  <= 1'b0;
              state_q <= cri_pkg::CRI_MACK;
            end
            else
            begin
              sda_oe  <= !shift_q[7];
              shift_q <= {shift_q[6:0], 1'b0};
              bit_q   <= bit_q + 3'h1;
            end
          end
        cri_pkg::CRI_MACK:
          if (scl_rise)
          begin
            rx_nack_q <= pins_s[0];
            state_q   <= cri_pkg::CRI_IDLE;
          end
        default:
        begin
          state_q <= cri_pkg::CRI_IDLE;
          sda_oe  <= 1'b0;
        end
      endcase
    end
  end

  // channel one fields decoded for the analog side
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sync_tip_clamp_ch1 <= 2'h0;
      mux_sel_ch1        <= 1'b0;
      lpf_sel_ch1        <= 2'h0;
      bias_mode_ch1      <= 3'h0;
    end
    else
    begin
      sync_tip_clamp_ch1 <= ch_regs[cri_pkg::CLAMP_MSB:cri_pkg::CLAMP_LSB];
      mux_sel_ch1        <= ch_regs[cri_pkg::MUX_BIT];
      lpf_sel_ch1        <= ch_regs[cri_pkg::LPF_MSB:cri_pkg::LPF_LSB];
      bias_mode_ch1      <= ch_regs[cri_pkg::BIAS_MSB:0];
    end
  end
endmodule : cri_top

/* File: logic/cri_pkg.sv */
// Purpose: shared constants for the channel register i2c target
// Assumes: 10 MHz aclk, axi4-lite register access
// Notes:   byte addresses of the three channel registers and the status word
package cri_pkg;
  localparam logic [4:0]  ADDR_FIXED     = 5'h0b;
  localparam int          NUM_CH         = 3;
  localparam logic [11:0] OFF_CH1        = 12'h004;
  localparam logic [11:0] OFF_CH2        = 12'h008;
  localparam logic [11:0] OFF_CH3        = 12'h00c;
  localparam logic [11:0] OFF_STATUS     = 12'h010;
  localparam logic [7:0]  CH_RESET       = 8'h00;
  localparam logic [1:0]  SEL_RESET      = 2'h0;
  localparam int          CLAMP_MSB      = 7;
  localparam int          CLAMP_LSB      = 6;
  localparam int          MUX_BIT        = 5;
  localparam int          LPF_MSB        = 4;
  localparam int          LPF_LSB        = 3;
  localparam int          BIAS_MSB       = 2;
  localparam logic [1:0]  RESP_OKAY      = 2'h0;
  localparam logic [1:0]  RESP_SLVERR    = 2'h2;
  typedef enum logic [6:0] {
    CRI_IDLE = 7'h01,
    CRI_ADDR = 7'h02,
    CRI_AACK = 7'h04,
    CRI_RXB  = 7'h08,
    CRI_RACK = 7'h10,
    CRI_TXB  = 7'h20,
    CRI_MACK = 7'h40
  } cri_state_t;
endpackage : cri_pkg

/* File: logic/cri_sync.sv */
// Purpose: two flip-flop synchroniser for asynchronous pins
// Assumes: single aclk domain
// Notes:   first stage read only by second stage
`timescale 1ns/100ps
module cri_sync #(
  parameter int WIDTH = 2
) (
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_q;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      meta_q   <= '1;
      sync_out <= '1;
    end
    else
    begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule : cri_sync

/* File: logic/cri_axil.sv */
// Purpose: axi4-lite slave for channel register access
// Assumes: one outstanding write and read
// Notes:   unmapped addresses answer slverr, read as zero
`timescale 1ns/100ps
module cri_axil (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic [23:0]      ch_regs,
  input  wire logic [7:0]  status_in
);
  logic        aw_have_q;
  logic        w_have_q;
  logic [11:0] aw_addr_q;
  logic [7:0]  w_byte_q;
  logic        w_en_q;
  logic        do_write;

  assign do_write = aw_have_q && w_have_q && !s_axi_bvalid;

  // write address and data taken in either order
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_have_q     <= 1'b0;
      w_have_q      <= 1'b0;
      aw_addr_q     <= 12'h000;
      w_byte_q      <= 8'h00;
      w_en_q        <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
    end
    else
    begin
      s_axi_awready <= !aw_have_q && !s_axi_awready && s_axi_awvalid;
      s_axi_wready  <= !w_have_q && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_have_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      else if (do_write)
        aw_have_q <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_have_q <= 1'b1;
        w_byte_q <= s_axi_wdata[7:0];
        w_en_q   <= s_axi_wstrb[0];
      end
      else if (do_write)
        w_have_q <= 1'b0;
    end
  end

  // channel register store and write response
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ch_regs      <= {cri_pkg::NUM_CH{cri_pkg::CH_RESET}};
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= cri_pkg::RESP_OKAY;
    end
    else if (do_write)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= cri_pkg::RESP_OKAY;
      case (aw_addr_q)
        cri_pkg::OFF_CH1: if (w_en_q) ch_regs[7:0]   <= w_byte_q;
        cri_pkg::OFF_CH2: if (w_en_q) ch_regs[15:8]  <= w_byte_q;
        cri_pkg::OFF_CH3: if (w_en_q) ch_regs[23:16] <= w_byte_q;
        cri_pkg::OFF_STATUS: s_axi_bresp <= cri_pkg::RESP_OKAY;
        default: s_axi_bresp <= cri_pkg::RESP_SLVERR;
      endcase
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  // read channel
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= cri_pkg::RESP_OKAY;
    end
    else
    begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= cri_pkg::RESP_OKAY;
        case (s_axi_araddr)
          cri_pkg::OFF_CH1:    s_axi_rdata <= {24'h000000, ch_regs[7:0]};
          cri_pkg::OFF_CH2:    s_axi_rdata <= {24'h000000, ch_regs[15:8]};
          cri_pkg::OFF_CH3:    s_axi_rdata <= {24'h000000, ch_regs[23:16]};
          cri_pkg::OFF_STATUS: s_axi_rdata <= {24'h000000, status_in};
          default:
          begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= cri_pkg::RESP_SLVERR;
          end
        endcase
      end
      else if (s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end
endmodule : cri_axil

/* File: bench/cri_checker.sv */
// Purpose: port assertions for the channel register i2c target
// Assumes: raw scl and sda sampled by aclk
// Notes:   bound to cri_top below
`timescale 1ns/100ps
module cri_checker (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        scl_i,
  input wire logic        sda_i,
  input wire logic        sda_oe,
  input wire logic        addr_strap_high,
  input wire logic        addr_strap_low,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0]  s_axi_wstrb,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic [11:0] s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic [1:0]  sync_tip_clamp_ch1,
  input wire logic        mux_sel_ch1,
  input wire logic [1:0]  lpf_sel_ch1,
  input wire logic [2:0]  bias_mode_ch1
);
  logic        scl_q, sda_q, dir_q, hit_q, miss_q, ws_q, rise, start, stop, ninth;
  logic [3:0]  bit_q;
  logic [1:0]  byte_q;
  logic [6:0]  sh_q, own;
  logic [7:0]  rx, wd_q;
  logic [11:0] wa_q;
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  function automatic logic mapped(input logic [11:0] a);
    return a == 12'h004 || a == 12'h008 || a == 12'h00c || a == 12'h010;
  endfunction : mapped
  assign rise  = scl_i && !scl_q;
  assign ninth = rise && bit_q == 4'h8;
  assign start = scl_i && scl_q && sda_q && !sda_i;
  assign stop  = scl_i && scl_q && !sda_q && sda_i;
  assign rx    = {sh_q, sda_i};
  assign own   = {5'h0b, addr_strap_high, addr_strap_low};
  always_ff @(posedge aclk)
  begin
    scl_q <= scl_i;
    sda_q <= sda_i;
  end
  always_ff @(posedge aclk)
  begin
    if (!aresetn || start || stop)
    begin
      bit_q  <= 4'h0;
      byte_q <= start ? 2'h0 : 2'h3;
      hit_q  <= 1'b0;
      miss_q <= 1'b0;
    end
    else if (rise)
    begin
      bit_q <= (bit_q == 4'h8) ? 4'h0 : bit_q + 4'h1;
      sh_q  <= rx[6:0];
      if (bit_q == 4'h8 && byte_q != 2'h3)
        byte_q <= byte_q + 2'h1;
      if (bit_q == 4'h7 && byte_q == 2'h0)
      begin
        hit_q  <= rx[7:1] == own;
        miss_q <= rx[7:1] != own;
        dir_q  <= rx[0];
      end
    end
  end
  always_ff @(posedge aclk)
  begin
    if (s_axi_awvalid && s_axi_awready)
      wa_q <= s_axi_awaddr;
    if (s_axi_wvalid && s_axi_wready)
    begin
      wd_q <= s_axi_wdata[7:0];
      ws_q <= s_axi_wstrb[0];
    end
  end
  chk_miss_silent: assert property (miss_q |-> !sda_oe)
    else $error("sda driven for foreign address");
  chk_addr_ack: assert property (ninth && byte_q == 2'h0 && hit_q |-> ##2 sda_oe)
    else $error("own address not acknowledged");
  chk_sub_ack: assert property (
    ninth && byte_q == 2'h1 && hit_q && !dir_q |-> ##2 sda_oe)
    else $error("subaddress not acknowledged");
  chk_no_extra: assert property (
    ninth && byte_q == 2'h2 && hit_q && !dir_q |-> ##2 !sda_oe)
    else $error("extra byte acknowledged");
  chk_read_release: assert property (
    ninth && byte_q == 2'h1 && hit_q && dir_q |-> ##2 !sda_oe)
    else $error("sda held after data byte");
  chk_ch1_fields: assert property (
    $rose(s_axi_bvalid) && wa_q == 12'h004 && ws_q |-> ##[0:2]
    ({sync_tip_clamp_ch1, mux_sel_ch1, lpf_sel_ch1, bias_mode_ch1} == wd_q))
    else $error("channel one fields wrong");
  chk_rd_unmapped: assert property (
    s_axi_arvalid && s_axi_arready && !mapped(s_axi_araddr) |->
    ##[1:2] (s_axi_rvalid && s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0))
    else $error("unmapped read answer wrong");
  chk_wr_unmapped: assert property (
    $rose(s_axi_bvalid) && !mapped(wa_q) |-> s_axi_bresp == 2'h2)
    else $error("unmapped write answer wrong");
endmodule : cri_checker
bind cri_top cri_checker chk (.aclk, .aresetn, .scl_i, .sda_i, .sda_oe, .addr_strap_high,
  .addr_strap_low, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
  .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_araddr,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
  .sync_tip_clamp_ch1, .mux_sel_ch1, .lpf_sel_ch1, .bias_mode_ch1);

/* File: bench/cri_i2c_master.sv */
// Purpose: behavioural i2c bus master for the channel register target
// Assumes: open-drain sda with pull-up, scl idles high
// Notes:   800 ns scl, data changed mid low phase
`timescale 1ns/100ps
module cri_i2c_master (
  input  wire logic aclk,
  input  wire logic sda,
  output logic      scl,
  output logic      sda_drive
);
  initial
  begin
    scl = 1'b1;
    sda_drive = 1'b0;
  end
  task wt(input int n);
    repeat (n) @(posedge aclk);
  endtask : wt
  task bitx(input logic b, output logic r);
    sda_drive <= ~b;
    wt(2);
    scl <= 1'b1;
    wt(2);
    r = sda;
    wt(2);
    scl <= 1'b0;
    wt(2);
  endtask : bitx
  task start();
    sda_drive <= 1'b0;
    scl <= 1'b1;
    wt(4);
    sda_drive <= 1'b1;
    wt(4);
    scl <= 1'b0;
    wt(2);
  endtask : start
  task stop();
    sda_drive <= 1'b1;
    wt(2);
    scl <= 1'b1;
    wt(4);
    sda_drive <= 1'b0;
    wt(4);
  endtask : stop
  task put_byte(input logic [7:0] v, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
      bitx(v[i], r);
    bitx(1'b1, r);
    ack = ~r;
  endtask : put_byte
  // one full two-transaction read per channel; extra breaks the single byte rule
  task read_chan(input logic [6:0] a, input logic [7:0] sub, input logic extra,
                 output logic [7:0] d, output logic [3:0] ak);
    logic r;
    ak = 4'h0;
    start();
    put_byte({a, 1'b0}, ak[0]);
    put_byte(sub, ak[1]);
    if (extra)
      put_byte(8'h5a, ak[2]);
    stop();
    start();
    put_byte({a, 1'b1}, ak[3]);
    for (int i = 0; i < 8; i++)
    begin
      bitx(1'b1, r);
      d = {d[6:0], r};
    end
    bitx(1'b1, r);
    stop();
  endtask : read_chan
endmodule : cri_i2c_master

/* File: bench/testbench.sv */
// Purpose: self-checking bench for the channel register i2c target
// Assumes: 10 MHz aclk, 800 ns scl from the master model
// Notes:   registers loaded over axi4-lite, read back over i2c
`timescale 1ns/100ps
module testbench;
  logic        aclk = 1'b0, aresetn = 1'b0, scl_i, sda_i, sda_o, sda_oe, m_oe;
  logic        addr_strap_high = 1'b1, addr_strap_low = 1'b0;
  logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, q;
  logic [3:0]  s_axi_wstrb = 4'h0, ak;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, mux_sel_ch1;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, sync_tip_clamp_ch1, lpf_sel_ch1, r;
  logic [2:0]  bias_mode_ch1;
  logic [7:0]  vals [1:3], d;
  int          fails = 0, num_checks = 0;
  assign sda_i = (sda_oe ? sda_o : 1'b1) & ~m_oe;
  always #50 aclk = ~aclk;
  cri_top uut (.aclk, .aresetn, .scl_i, .sda_i, .sda_o, .sda_oe, .addr_strap_high,
    .addr_strap_low, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .sync_tip_clamp_ch1, .mux_sel_ch1, .lpf_sel_ch1,
    .bias_mode_ch1);
  cri_i2c_master m (.aclk(aclk), .sda(sda_i), .scl(scl_i), .sda_drive(m_oe));
  task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task summarize();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : summarize
  task do_reset();
    aresetn <= 1'b0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (6) @(posedge aclk);
  endtask : do_reset
  task axi_wr(input logic [11:0] a, input logic [31:0] v, input logic [3:0] s,
              output logic [1:0] res);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    res = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : axi_wr
  task axi_rd(input logic [11:0] a, output logic [31:0] v, output logic [1:0] res);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_arready)
        s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    v = s_axi_rdata;
    res = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : axi_rd
  initial
  begin
    repeat (20000) @(posedge aclk);
    fails++;
    summarize();
  end
  initial
  begin
    vals[1] = 8'hf5;
    vals[2] = 8'h3a;
    vals[3] = 8'hc6;
    do_reset();
    axi_rd(12'h008, q, r);
    check("ch2 after reset", q, 32'h0);
    for (int c = 1; c <= 3; c++)
    begin
      axi_wr(12'(4 * c), {24'h0, vals[c]}, 4'hf, r);
      check("write resp", r, 2'h0);
    end
    axi_wr(12'h004, 32'h0, 4'he, r);
    axi_rd(12'h004, q, r);
    check("ch1 strobe off", q, {24'h0, vals[1]});
    check("ch1 fields", {sync_tip_clamp_ch1, mux_sel_ch1, lpf_sel_ch1, bias_mode_ch1},
          vals[1]);
    axi_wr(12'h020, 32'h1, 4'hf, r);
    check("unmapped write", r, 2'h2);
    axi_rd(12'h020, q, r);
    check("unmapped data", q, 32'h0);
    check("unmapped resp", r, 2'h2);
    $display("test axi done");
    for (int c = 3; c >= 1; c--)
    begin
      m.read_chan({5'h0b, addr_strap_high, addr_strap_low}, 8'(c), 1'b0, d, ak);
      check("read acks", ak, 4'hb);
      check("read data", d, vals[c]);
    end
    m.read_chan({5'h0b, addr_strap_high, addr_strap_low}, 8'h01, 1'b1, d, ak);
    check("extra byte acks", ak, 4'hb);
    check("extra byte data", d, vals[1]);
    axi_wr(12'h008, 32'h81, 4'hf, r);
    m.read_chan({5'h0b, addr_strap_high, addr_strap_low}, 8'h02, 1'b0, d, ak);
    check("current data", d, 8'h81);
    m.read_chan({5'h0b, ~addr_strap_high, addr_strap_low}, 8'h01, 1'b0, d, ak);
    check("foreign acks", ak, 4'h0);
    check("foreign data", d, 8'hff);
    $display("test i2c done");
    addr_strap_high <= 1'b0;
    addr_strap_low <= 1'b1;
    do_reset();
    m.read_chan(7'h2d, 8'h03, 1'b0, d, ak);
    check("new strap acks", ak, 4'hb);
    check("new strap data", d, 8'h00);
    m.read_chan(7'h2e, 8'h03, 1'b0, d, ak);
    check("old strap acks", ak, 4'h0);
    $display("test strap done");
    summarize();
  end
endmodule : testbench
